// ### logic/processor_state_trap_regs.sv
`timescale 1ns/100ps
// Summary of operation
// - coprocessor enable bit: one enabled, zero disabled
// - float enable bit: one enabled, zero disabled
// - float instruction traps when disabled or absent
// - coprocessor instruction traps when disabled or absent
// - level fifteen always passes the mask, else above mask
// - privilege bit one means supervisor mode
// - state writes need supervisor privilege
// - trap saves privilege; return restores it
// - traps disabled ignore all interrupts
// - synchronous trap while disabled enters error mode
// - window pointer steps modulo seven
// - writing unimplemented window is illegal instruction
// - masked target window raises overflow/underflow
// - seven mask bits; upper bits read zero
// - base write loads upper twenty bits
// - reset trap vectors to address zero
// - trap code stored, writes ignored
// - low four base bits hardwired zero
// - thirty-two bit multiply step high register
// - counter takes next; next steps or jumps
// - counters not reachable by register access
// - trap saves both counters to new window
module processor_state_trap_regs #(
	parameter int NWIN = state_regs_pkg::NWIN
) (
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	// instruction advance
	input  wire logic        step_in,
	input  wire logic        xfer_in,
	input  wire logic [31:0] xfer_target_in,
	// special register port
	input  wire logic        sreg_wr_in,
	input  wire logic        sreg_rd_in,
	input  wire logic [1:0]  sreg_sel_in,
	input  wire logic [31:0] sreg_wdata_in,
	output logic      [31:0] sreg_rdata_out,
	// multiply step update of the high word
	input  wire logic        mul_step_in,
	input  wire logic [31:0] mul_y_in,
	// instruction classes
	input  wire logic        float_instr_in,
	input  wire logic        coproc_instr_in,
	input  wire logic        float_unit_attached_in,
	input  wire logic        coproc_attached_in,
	input  wire logic [2:0]  win_op_in,
	input  wire logic        return_from_trap_instr_in,
	// other synchronous trap request from the integer unit
	input  wire logic        sync_trap_in,
	input  wire logic [7:0]  sync_trap_code_in,
	input  wire logic [3:0]  irq_level_in,
	// state
	output logic             coproc_enable_bit_out,
	output logic             float_unit_enable_bit_out,
	output logic             supervisor_out,
	output logic      [4:0]  active_window_index_out,
	output logic      [31:0] pc_out,
	output logic      [31:0] next_program_counter_out,
	// trap side effects
	output logic             trap_taken_out,
	output logic             error_mode_out,
	output logic      [4:0]  save_window_out,
	output logic      [31:0] save_pc_out,
	output logic      [31:0] save_npc_out
);
	logic        ec_r, ef_r, s_r, ps_r, et_r, err_r, tk_r;
	logic [3:0]  pil_r;
	logic [4:0]  cwp_r, cwp_dec, cwp_inc, sw_r;
	logic [6:0]  wim_r;
	logic [19:0] tba_r;
	logic [7:0]  tt_r;
	logic [31:0] y_r, pc_r, npc_r, spc_r, snpc_r;
	logic        dec_hit, inc_hit;
	logic        wr_ok, illegal, fp_dis, cp_dis, wovf, wunf;
	logic        sync_req, irq_ok, trap_go;
	logic [7:0]  trap_code;

	function automatic logic win_valid(input logic [4:0] w);
		win_valid = (w < 5'(NWIN));
	endfunction

	window_step u_step (
		.cur_in      (cwp_r),
		.mask_in     (wim_r),
		.dec_out     (cwp_dec),
		.inc_out     (cwp_inc),
		.dec_hit_out (dec_hit),
		.inc_hit_out (inc_hit)
	);

	// user-mode register writes are refused as illegal
	assign wr_ok   = sreg_wr_in && s_r;
	assign illegal = sreg_wr_in && (!s_r || (sreg_sel_in ==
		state_regs_pkg::SEL_STATE &&
		!win_valid(sreg_wdata_in[state_regs_pkg::CWP_HI:0])));
	assign fp_dis  = float_instr_in &&
		(!ef_r || !float_unit_attached_in);
	assign cp_dis  = coproc_instr_in &&
		(!ec_r || !coproc_attached_in);
	assign wovf = (win_op_in == state_regs_pkg::WOP_SAVE) && dec_hit;
	assign wunf = (win_op_in == state_regs_pkg::WOP_RESTORE ||
		win_op_in == state_regs_pkg::WOP_RETURN_FROM_TRAP_INSTR ||
		return_from_trap_instr_in) && inc_hit;
	assign sync_req = fp_dis || cp_dis || wovf || wunf || illegal ||
		sync_trap_in;
	assign irq_ok = (irq_level_in == state_regs_pkg::IRL_NMI) ||
		(irq_level_in > pil_r);
	assign trap_go = !err_r && et_r && (sync_req || irq_ok);

	always_comb begin
		trap_code = state_regs_pkg::TT_IRQ_BASE + {4'h0, irq_level_in};
		if (illegal)
			trap_code = state_regs_pkg::TT_ILLEGAL;
		else if (fp_dis)
			trap_code = state_regs_pkg::TT_FP_DIS;
		else if (cp_dis)
			trap_code = state_regs_pkg::TT_CP_DIS;
		else if (wovf)
			trap_code = state_regs_pkg::TT_WOVF;
		else if (wunf)
			trap_code = state_regs_pkg::TT_WUNF;
		else if (sync_trap_in)
			trap_code = sync_trap_code_in;
	end

	// error mode is sticky until reset
	always_ff @(posedge ref_clk_in) begin
		if (rst_in)
			err_r <= 1'b0;
		else if (!et_r && sync_req)
			err_r <= 1'b1;
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			s_r  <= 1'b1;
			ps_r <= 1'b1;
			et_r <= 1'b0;
			ec_r <= 1'b0;
			ef_r <= 1'b0;
			pil_r <= 4'h0;
			cwp_r <= state_regs_pkg::WIN_FIRST;
		end else if (trap_go) begin
			ps_r  <= s_r;
			s_r   <= 1'b1;
			et_r  <= 1'b0;
			cwp_r <= cwp_dec;
		end else if (!err_r && wr_ok && !illegal &&
				sreg_sel_in == state_regs_pkg::SEL_STATE) begin
			ec_r  <= sreg_wdata_in[state_regs_pkg::EC_BIT];
			ef_r  <= sreg_wdata_in[state_regs_pkg::EF_BIT];
			pil_r <= sreg_wdata_in[state_regs_pkg::PIL_HI:
				state_regs_pkg::PIL_LO];
			s_r   <= sreg_wdata_in[state_regs_pkg::S_BIT];
			ps_r  <= sreg_wdata_in[state_regs_pkg::PS_BIT];
			et_r  <= sreg_wdata_in[state_regs_pkg::ET_BIT];
			cwp_r <= sreg_wdata_in[state_regs_pkg::CWP_HI:0];
		end else if (!err_r && step_in) begin
			case (win_op_in)
				state_regs_pkg::WOP_SAVE: cwp_r <= cwp_dec;
				state_regs_pkg::WOP_RESTORE: cwp_r <= cwp_inc;
				state_regs_pkg::WOP_RETURN_FROM_TRAP_INSTR: begin
					cwp_r <= cwp_inc;
					s_r   <= ps_r;
					et_r  <= 1'b1;
				end
				default: cwp_r <= cwp_r;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in)
			wim_r <= 7'h00;
		else if (!err_r && !trap_go && wr_ok &&
				sreg_sel_in == state_regs_pkg::SEL_WMASK)
			wim_r <= sreg_wdata_in[6:0];
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			tba_r <= 20'h00000;
			tt_r  <= 8'h00;
		end else if (trap_go) begin
			tt_r <= trap_code;
		end else if (!err_r && wr_ok &&
				sreg_sel_in == state_regs_pkg::SEL_TBASE) begin
			tba_r <= sreg_wdata_in[31:state_regs_pkg::TBA_LO];
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in)
			y_r <= 32'h00000000;
		else if (!err_r && !trap_go && wr_ok &&
				sreg_sel_in == state_regs_pkg::SEL_YREG)
			y_r <= sreg_wdata_in;
		else if (!err_r && !trap_go && mul_step_in)
			y_r <= mul_y_in;
	end

	// counters change only through sequencing and traps, never the register port
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			pc_r  <= state_regs_pkg::RESET_VECTOR;
			npc_r <= state_regs_pkg::RESET_VECTOR + state_regs_pkg::PC_STEP;
		end else if (trap_go) begin
			pc_r  <= {tba_r, trap_code, 4'h0};
			npc_r <= {tba_r, trap_code, 4'h0} + state_regs_pkg::PC_STEP;
		end else if (!err_r && step_in) begin
			pc_r  <= npc_r;
			npc_r <= xfer_in ? xfer_target_in
				: npc_r + state_regs_pkg::PC_STEP;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			tk_r   <= 1'b0;
			sw_r   <= 5'h00;
			spc_r  <= 32'h00000000;
			snpc_r <= 32'h00000000;
		end else begin
			tk_r <= trap_go;
			if (trap_go) begin
				sw_r   <= cwp_dec;
				spc_r  <= pc_r;
				snpc_r <= npc_r;
			end
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in)
			sreg_rdata_out <= 32'h00000000;
		else if (sreg_rd_in && s_r) begin
			case (sreg_sel_in)
				state_regs_pkg::SEL_STATE: sreg_rdata_out <= {18'h00000,
					ec_r, ef_r, pil_r, s_r, ps_r, et_r, cwp_r};
				state_regs_pkg::SEL_WMASK:
					sreg_rdata_out <= {25'h0000000, wim_r};
				state_regs_pkg::SEL_TBASE:
					sreg_rdata_out <= {tba_r, tt_r, 4'h0};
				default: sreg_rdata_out <= y_r;
			endcase
		end
	end

	assign coproc_enable_bit_out     = ec_r;
	assign float_unit_enable_bit_out = ef_r;
	assign supervisor_out            = s_r;
	assign active_window_index_out   = cwp_r;
	assign pc_out                    = pc_r;
	assign next_program_counter_out  = npc_r;
	assign trap_taken_out            = tk_r;
	assign error_mode_out            = err_r;
	assign save_window_out           = sw_r;
	assign save_pc_out               = spc_r;
	assign save_npc_out              = snpc_r;
endmodule

// ### logic/window_step.sv
`timescale 1ns/100ps
// modulo-seven window pointer neighbours and their mask check
module window_step (
	input  wire logic [4:0] cur_in,
	input  wire logic [6:0] mask_in,
	output logic      [4:0] dec_out,
	output logic      [4:0] inc_out,
	output logic            dec_hit_out,
	output logic            inc_hit_out
);
	always_comb begin
		dec_out = (cur_in == state_regs_pkg::WIN_FIRST) ?
			state_regs_pkg::WIN_LAST : cur_in - 5'h01;
		inc_out = (cur_in >= state_regs_pkg::WIN_LAST) ?
			state_regs_pkg::WIN_FIRST : cur_in + 5'h01;
		dec_hit_out = mask_in[dec_out[2:0]];
		inc_hit_out = mask_in[inc_out[2:0]];
	end
endmodule

// ### pkg/state_regs_pkg.sv
package state_regs_pkg;
	localparam int          XLEN           = 32;
	localparam int          NWIN           = 7;
	localparam int          WIN_W          = 5;
	localparam int          IRL_W          = 4;
	localparam int          TT_W           = 8;
	// processor_state field positions
	localparam int          EC_BIT         = 13;
	localparam int          EF_BIT         = 12;
	localparam int          PIL_HI         = 11;
	localparam int          PIL_LO         = 8;
	localparam int          S_BIT          = 7;
	localparam int          PS_BIT         = 6;
	localparam int          ET_BIT         = 5;
	localparam int          CWP_HI         = 4;
	// trap_vector_base field positions
	localparam int          TBA_LO         = 12;
	localparam int          TT_HI          = 11;
	localparam int          TT_LO          = 4;
	localparam int          NULL_HI        = 3;
	// values
	localparam logic [3:0]  IRL_NMI        = 4'hf;
	localparam logic [31:0] PC_STEP        = 32'h00000004;
	localparam logic [31:0] RESET_VECTOR   = 32'h00000000;
	localparam logic [4:0]  WIN_LAST       = 5'h06;
	localparam logic [4:0]  WIN_FIRST      = 5'h00;
	localparam logic [7:0]  TT_FP_DIS      = 8'h04;
	localparam logic [7:0]  TT_CP_DIS      = 8'h24;
	localparam logic [7:0]  TT_WOVF        = 8'h05;
	localparam logic [7:0]  TT_WUNF        = 8'h06;
	localparam logic [7:0]  TT_ILLEGAL     = 8'h02;
	localparam logic [7:0]  TT_IRQ_BASE    = 8'h10;
	// special register selectors for the read/write port
	typedef enum logic [1:0] {
		SEL_STATE = 2'b00,
		SEL_WMASK = 2'b01,
		SEL_TBASE = 2'b10,
		SEL_YREG  = 2'b11
	} sreg_sel_t;
	// window pointer operations
	typedef enum logic [2:0] {
		WOP_NONE    = 3'b000,
		WOP_SAVE    = 3'b001,
		WOP_RESTORE = 3'b010,
		WOP_RETURN_FROM_TRAP_INSTR    = 3'b011
	} win_op_t;
endpackage

// ### verif/processor_state_trap_regs_checker.sv
`timescale 1ns/100ps
module processor_state_trap_regs_checker #(
	parameter int NWIN = state_regs_pkg::NWIN
) (
	input wire logic        ref_clk_in,
	input wire logic        rst_in,
	input wire logic        step_in,
	input wire logic        xfer_in,
	input wire logic [31:0] xfer_target_in,
	input wire logic        sreg_wr_in,
	input wire logic        sreg_rd_in,
	input wire logic [1:0]  sreg_sel_in,
	input wire logic [31:0] sreg_rdata_out,
	input wire logic        float_instr_in,
	input wire logic        coproc_instr_in,
	input wire logic [2:0]  win_op_in,
	input wire logic        sync_trap_in,
	input wire logic [3:0]  irq_level_in,
	input wire logic        supervisor_out,
	input wire logic [4:0]  active_window_index_out,
	input wire logic [31:0] pc_out,
	input wire logic [31:0] next_program_counter_out,
	input wire logic        trap_taken_out,
	input wire logic        error_mode_out,
	input wire logic [4:0]  save_window_out,
	input wire logic [31:0] save_pc_out,
	input wire logic [31:0] save_npc_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	// no cause of any trap present, so the step must go through
	sequence quiet_s;
		!sreg_wr_in && !float_instr_in && !coproc_instr_in && !sync_trap_in
		&& irq_level_in == 4'h0 && win_op_in == 3'h0 && !error_mode_out;
	endsequence
	AST_STEP_SEQ: assert property (step_in && !xfer_in ##0 quiet_s |=>
		pc_out == $past(next_program_counter_out) &&
		next_program_counter_out == $past(next_program_counter_out) + 32'h4)
		else $error("sequential step wrong");
	AST_XFER_TGT: assert property (step_in && xfer_in ##0 quiet_s |=>
		next_program_counter_out == $past(xfer_target_in))
		else $error("transfer target not taken");
	AST_TRAP_WIN: assert property (
		trap_taken_out |-> pc_out[3:0] == 4'h0 &&
		active_window_index_out == ($past(active_window_index_out) == 5'h0 ?
		5'(NWIN - 1) : $past(active_window_index_out) - 5'h1))
		else $error("trap window or vector wrong");
	AST_TRAP_SAVE: assert property (
		trap_taken_out |-> supervisor_out && save_pc_out == $past(pc_out) &&
		save_window_out == active_window_index_out &&
		save_npc_out == $past(next_program_counter_out))
		else $error("trap save wrong");
	AST_TRAP_ONCE: assert property (trap_taken_out |=> !trap_taken_out)
		else $error("trap taken with traps off");
	AST_RESET_STATE: assert property (
		$fell(rst_in) |-> supervisor_out && pc_out == 32'h0 &&
		next_program_counter_out == 32'h4 && !error_mode_out)
		else $error("reset state wrong");
	AST_ERR_HOLD: assert property (error_mode_out |=>
		error_mode_out && $stable(pc_out) && !trap_taken_out)
		else $error("error mode left");
	AST_MASK_RD: assert property (sreg_rd_in && sreg_sel_in == 2'h1 &&
		supervisor_out |=> sreg_rdata_out[31:7] == 25'h0)
		else $error("mask upper bits set");
endmodule
bind processor_state_trap_regs processor_state_trap_regs_checker #(.NWIN(NWIN))
	u_chk (.ref_clk_in, .rst_in, .step_in, .xfer_in, .xfer_target_in,
	.sreg_wr_in, .sreg_rd_in, .sreg_sel_in, .sreg_rdata_out, .float_instr_in,
	.coproc_instr_in, .win_op_in, .sync_trap_in, .irq_level_in, .supervisor_out,
	.active_window_index_out, .pc_out, .next_program_counter_out,
	.trap_taken_out, .error_mode_out, .save_window_out, .save_pc_out,
	.save_npc_out);

// ### verif/processor_state_trap_regs_tb.sv
`timescale 1ns/100ps
module processor_state_trap_regs_tb;
	logic        ref_clk_in = 1'b0, rst_in = 1'b1, step_in = 1'b0;
	logic        xfer_in = 1'b0, mul_step_in = 1'b0, sync_trap_in = 1'b0;
	logic        sreg_wr_in = 1'b0, sreg_rd_in = 1'b0;
	logic        float_instr_in = 1'b0, coproc_instr_in = 1'b0;
	logic        float_unit_attached_in = 1'b1, coproc_attached_in = 1'b1;
	logic        return_from_trap_instr_in = 1'b0;
	logic [1:0]  sreg_sel_in = 2'h0;
	logic [2:0]  win_op_in = 3'h0;
	logic [3:0]  irq_level_in = 4'h0;
	logic [7:0]  sync_trap_code_in = 8'h00;
	logic [31:0] xfer_target_in = 32'h0, sreg_wdata_in = 32'h0;
	logic [31:0] mul_y_in = 32'h0, sreg_rdata_out, pc_out, d, m_tba;
	logic [31:0] next_program_counter_out, save_pc_out, save_npc_out;
	logic [31:0] m_pc = 32'h0, m_npc = 32'h4;
	logic [4:0]  active_window_index_out, save_window_out;
	logic        coproc_enable_bit_out, float_unit_enable_bit_out;
	logic        supervisor_out, trap_taken_out, error_mode_out;
	int          n_fail = 0, samples_checked = 0, cyc = 0, m_cwp = 0;
	wire [1:0]   en = {coproc_enable_bit_out, float_unit_enable_bit_out};
	always #20 ref_clk_in = ~ref_clk_in;
	processor_state_trap_regs u_dut (.ref_clk_in, .rst_in, .step_in,
		.xfer_in, .xfer_target_in, .sreg_wr_in, .sreg_rd_in, .sreg_sel_in,
		.sreg_wdata_in, .sreg_rdata_out, .mul_step_in, .mul_y_in,
		.float_instr_in, .coproc_instr_in, .float_unit_attached_in,
		.coproc_attached_in, .win_op_in, .return_from_trap_instr_in,
		.sync_trap_in, .sync_trap_code_in, .irq_level_in,
		.coproc_enable_bit_out, .float_unit_enable_bit_out, .supervisor_out,
		.active_window_index_out, .pc_out, .next_program_counter_out,
		.trap_taken_out, .error_mode_out, .save_window_out, .save_pc_out,
		.save_npc_out);
	task automatic test_done;
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [1:0] s, input logic [31:0] v);
		// one idle edge keeps back-to-back write strobes apart
		@(negedge ref_clk_in);
		sreg_sel_in = s;
		sreg_wdata_in = v;
		sreg_wr_in = 1'b1;
		@(negedge ref_clk_in);
		sreg_wr_in = 1'b0;
		if (s == 2'h0)
			m_cwp = int'(v[4:0]);
	endtask
	task automatic rd(input logic [1:0] s, input logic [31:0] e);
		sreg_sel_in = s;
		sreg_rd_in = 1'b1;
		@(negedge ref_clk_in);
		sreg_rd_in = 1'b0;
		chk("rdata", e, sreg_rdata_out);
	endtask
	// one instruction; the model counters follow the delayed transfer
	task automatic stp(input logic x, input logic [2:0] op);
		xfer_target_in = $urandom & 32'hfffffffc;
		xfer_in = x;
		win_op_in = op;
		return_from_trap_instr_in = (op == 3'h3);
		step_in = 1'b1;
		@(negedge ref_clk_in);
		step_in = 1'b0;
		win_op_in = 3'h0;
		return_from_trap_instr_in = 1'b0;
		m_pc = m_npc;
		m_npc = x ? xfer_target_in : m_npc + 32'h4;
		if (op != 3'h0)
			m_cwp = (m_cwp + 1) % 7;
		chk("pc", m_pc, pc_out);
		chk("npc", m_npc, next_program_counter_out);
		chk("cwp", 32'(m_cwp), 32'(active_window_index_out));
	endtask
	// cause must already be applied; trap lands at the next edge
	task automatic trp(input logic [7:0] c);
		@(negedge ref_clk_in);
		m_cwp = (m_cwp + 6) % 7;
		chk("taken", 32'h1, 32'(trap_taken_out));
		chk("save_pc", m_pc, save_pc_out);
		chk("save_npc", m_npc, save_npc_out);
		m_pc = {m_tba[31:12], c, 4'h0};
		m_npc = m_pc + 32'h4;
		chk("vector", m_pc, pc_out);
		chk("cwp", 32'(m_cwp), 32'(active_window_index_out));
		chk("super", 32'h1, 32'(supervisor_out));
	endtask
	task automatic wtrap(input logic [1:0] s, input logic [31:0] v);
		@(negedge ref_clk_in);
		sreg_sel_in = s;
		sreg_wdata_in = v;
		sreg_wr_in = 1'b1;
		trp(state_regs_pkg::TT_ILLEGAL);
		sreg_wr_in = 1'b0;
	endtask
	always @(posedge ref_clk_in) begin
		cyc++;
		if (cyc > 4000) begin
			n_fail++;
			test_done();
		end
	end
	initial begin
		void'($urandom(32'h3812454d));
		repeat (16) @(negedge ref_clk_in);
		rst_in = 1'b0;
		rd(2'h0, 32'h000000c0);
		d = $urandom;
		wr(2'h1, d);
		rd(2'h1, d & 32'h7f);
		wr(2'h1, 32'h0);
		d = $urandom;
		m_tba = d & 32'hfffff000;
		wr(2'h2, d);
		rd(2'h2, m_tba);
		wr(2'h3, d);
		rd(2'h3, d);
		mul_y_in = ~d;
		mul_step_in = 1'b1;
		@(negedge ref_clk_in);
		mul_step_in = 1'b0;
		rd(2'h3, ~d);
		repeat (8) begin
			stp(1'($urandom), 3'h0);
			@(negedge ref_clk_in);
		end
		wr(2'h0, 32'h35a3);
		rd(2'h0, 32'h35a3);
		chk("enables", 32'h3, 32'(en));
		irq_level_in = 4'h5;
		stp(1'b0, 3'h0);
		irq_level_in = 4'h6;
		trp(8'h16);
		irq_level_in = 4'hf;
		stp(1'b0, 3'h0);
		wr(2'h0, 32'h3fa3);
		trp(8'h1f);
		irq_level_in = 4'h0;
		wr(2'h0, 32'h20a3);
		float_instr_in = 1'b1;
		trp(state_regs_pkg::TT_FP_DIS);
		// drop the cause at once: with traps now off it would halt the unit
		float_instr_in = 1'b0;
		stp(1'b0, 3'h0);
		wr(2'h0, 32'h30a3);
		float_instr_in = 1'b1;
		float_unit_attached_in = 1'b0;
		trp(state_regs_pkg::TT_FP_DIS);
		float_instr_in = 1'b0;
		float_unit_attached_in = 1'b1;
		wr(2'h0, 32'h10a3);
		chk("enables", 32'h1, 32'(en));
		coproc_instr_in = 1'b1;
		trp(state_regs_pkg::TT_CP_DIS);
		coproc_instr_in = 1'b0;
		wr(2'h1, 32'h04);
		wr(2'h0, 32'h30a3);
		win_op_in = 3'h1;
		trp(state_regs_pkg::TT_WOVF);
		wr(2'h1, 32'h10);
		wr(2'h0, 32'h30a3);
		win_op_in = 3'h2;
		trp(state_regs_pkg::TT_WUNF);
		win_op_in = 3'h0;
		wr(2'h1, 32'h0);
		wr(2'h0, 32'h30a3);
		wtrap(2'h0, 32'h30a7);
		wr(2'h0, 32'h3023);
		chk("super", 32'h0, 32'(supervisor_out));
		wtrap(2'h3, $urandom);
		stp(1'b0, 3'h3);
		chk("super", 32'h0, 32'(supervisor_out));
		rst_in = 1'b1;
		repeat (2) @(negedge ref_clk_in);
		rst_in = 1'b0;
		sync_trap_code_in = 8'($urandom);
		sync_trap_in = 1'b1;
		@(negedge ref_clk_in);
		sync_trap_in = 1'b0;
		chk("error", 32'h1, 32'(error_mode_out));
		step_in = 1'b1;
		@(negedge ref_clk_in);
		step_in = 1'b0;
		chk("pc", 32'h0, pc_out);
		test_done();
	end
endmodule
